// ===== hdl/fsp_device.sv
module fsp_device
    import fsp_pkg::*;
#(
    parameter int OP_CNT     = OP_CYCLES,
    parameter int PAGE_WORDS = 64
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    fsp_if.dev        bus,
    input  wire logic eeprom_write_busy,
    output logic      flash_op_valid,
    output fsp_op_t   flash_op,
    output logic [7:0]  flash_page,
    output logic [15:0] flash_word,
    output logic        app_section_read_enable
);
    localparam int CW = $clog2(OP_CNT + 1);

    typedef struct packed {
        logic [4:0]    ctrl;
        logic [2:0]    win;
        logic          busy;
        logic [CW-1:0] cnt;
        fsp_op_t       op;
        logic [7:0]    page;
        logic [7:0]    rdata;
        logic [7:0]    ldata;
        logic          lvalid;
        logic          sdone;
        logic          ovalid;
        fsp_op_t       oop;
        logic [15:0]   oword;
        logic          app_en;
        logic [3:0]    lock_bits;
    } fsp_dev_state_t;

    fsp_dev_state_t st_reg;
    fsp_dev_state_t st_next;
    fsp_dev_state_t clr_reg;
    fsp_dev_state_t keep_reg;
    logic [15:0]    buf_mem [PAGE_WORDS];
    logic           buf_we;
    logic [5:0]     buf_idx;

    function automatic logic pattern_ok(input logic [4:0] p);
        return p == PAT_APP_READ || p == PAT_LOCK_SET ||
               p == PAT_PAGE_WRITE || p == PAT_PAGE_ERASE ||
               p == PAT_FILL;
    endfunction : pattern_ok

    assign buf_idx = bus.pointer[6:1];
    assign buf_we  = ce && st_next.sdone && st_reg.ctrl == PAT_FILL
                     && !st_reg.busy;

    // The fields that must outlive a reset come from their own register.
    always_comb begin
        st_reg           = clr_reg;
        st_reg.busy      = keep_reg.busy;
        st_reg.cnt       = keep_reg.cnt;
        st_reg.op        = keep_reg.op;
        st_reg.page      = keep_reg.page;
        st_reg.lock_bits = keep_reg.lock_bits;
    end

    always_comb begin
        st_next = st_reg;
        st_next.lvalid = 1'b0;
        st_next.sdone  = 1'b0;
        st_next.ovalid = 1'b0;
        if (st_reg.busy) begin
            if (st_reg.cnt == '0) begin
                st_next.busy = 1'b0;
                st_next.ctrl = '0;
                st_next.sdone = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - CW'(1);
            end
        end else if (bus.io_wr && bus.io_addr == CTRL_OFFSET) begin
            if (!eeprom_write_busy && pattern_ok(bus.io_wdata[4:0])) begin
                st_next.ctrl = bus.io_wdata[4:0];
                st_next.win  = '0;
            end
        end else if (st_reg.ctrl[BIT_STORE_EN]) begin
            if (bus.store_strobe && st_reg.win < STORE_WINDOW
                && !eeprom_write_busy) begin
                unique case (st_reg.ctrl)
                    PAT_PAGE_ERASE, PAT_PAGE_WRITE: begin
                        st_next.busy = 1'b1;
                        st_next.cnt  = CW'(OP_CNT);
                        st_next.page = bus.pointer[14:7];
                        st_next.op   = st_reg.ctrl == PAT_PAGE_ERASE ?
                            FSP_OP_ERASE : FSP_OP_WRITE;
                    end
                    PAT_LOCK_SET: begin
                        // Cleared source bits program lock bits.
                        st_next.lock_bits = st_reg.lock_bits &
                            bus.data_low_reg[LOCK_FIELD_LSB +: LOCK_FIELD_W];
                        st_next.ctrl  = '0;
                        st_next.sdone = 1'b1;
                    end
                    PAT_APP_READ: begin
                        st_next.app_en = 1'b1;
                        st_next.ctrl   = '0;
                        st_next.sdone  = 1'b1;
                    end
                    default: begin
                        st_next.ctrl  = '0;
                        st_next.sdone = 1'b1;
                        st_next.oop   = FSP_OP_FILL;
                        st_next.oword = {bus.data_high_reg, bus.data_low_reg};
                        st_next.ovalid = 1'b1;
                    end
                endcase
            end else if (bus.load_strobe && st_reg.ctrl == PAT_LOCK_SET
                         && st_reg.win < LOAD_WINDOW
                         && !eeprom_write_busy) begin
                unique case (bus.pointer[1:0])
                    ADDR_FUSE_LOW:  st_next.ldata = FUSE_LOW_RESET;
                    ADDR_LOCK:      st_next.ldata = {2'b11,
                                        st_reg.lock_bits, 2'b11};
                    ADDR_FUSE_HIGH: st_next.ldata = FUSE_HIGH_RESET;
                    default:        st_next.ldata = LOCK_RESET;
                endcase
                st_next.lvalid = 1'b1;
                st_next.ctrl   = '0;
            end else begin
                st_next.win = st_reg.win + 3'h1;
                // Lock set waits one cycle longer for a load.
                if ((st_reg.ctrl == PAT_LOCK_SET &&
                     st_reg.win + 3'h1 >= LOAD_WINDOW) ||
                    (st_reg.ctrl != PAT_LOCK_SET &&
                     st_reg.win + 3'h1 >= STORE_WINDOW))
                    st_next.ctrl = '0;
            end
        end
        if (st_next.busy && !st_reg.busy) begin
            st_next.ovalid = 1'b1;
            st_next.oop    = st_next.op;
            st_next.oword  = {8'h00, st_next.page};
            st_next.app_en = 1'b0;
        end
        if (bus.io_rd && bus.io_addr == CTRL_OFFSET)
            st_next.rdata = {1'b0, 1'b0, 1'b0, st_reg.ctrl};
        else
            st_next.rdata = '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_reg <= '{ctrl: CTRL_RESET[4:0], op: FSP_OP_NONE,
                         oop: FSP_OP_NONE, default: '0};
        end else if (ce) begin
            clr_reg <= st_next;
        end
    end

    // A running erase or write is carried to its end through reset, so
    // its fields sit outside the asynchronous reset. An unknown busy
    // flag at power-up falls into the clearing branch.
    always_ff @(posedge clk) begin
        if (rst) begin
            if (keep_reg.busy) begin
                if (ce) begin
                    keep_reg.busy <= keep_reg.cnt != '0;
                    keep_reg.cnt  <= keep_reg.cnt - CW'(1);
                end
            end else begin
                keep_reg.busy      <= 1'b0;
                keep_reg.cnt       <= '0;
                keep_reg.op        <= FSP_OP_NONE;
                keep_reg.page      <= '0;
                keep_reg.lock_bits <= '1;
            end
        end else if (ce) begin
            keep_reg.busy      <= st_next.busy;
            keep_reg.cnt       <= st_next.cnt;
            keep_reg.op        <= st_next.op;
            keep_reg.page      <= st_next.page;
            keep_reg.lock_bits <= st_next.lock_bits;
        end
    end

    always_ff @(posedge clk) begin
        if (buf_we)
            buf_mem[buf_idx] <= st_next.oword;
    end

    assign bus.io_rdata  = st_reg.rdata;
    assign bus.load_data = st_reg.ldata;
    assign bus.load_valid = st_reg.lvalid;
    assign bus.store_done = st_reg.sdone;
    assign bus.halt       = st_reg.busy;
    assign flash_op_valid = st_reg.ovalid;
    assign flash_op       = st_reg.oop;
    assign flash_page     = st_reg.page;
    assign flash_word     = st_reg.oword;
    assign app_section_read_enable = st_reg.app_en;
endmodule : fsp_device

// ===== hdl/fsp_pkg.sv
package fsp_pkg;
    localparam logic [7:0] CTRL_OFFSET      = 8'h37;
    localparam int         BIT_STORE_EN     = 0;
    localparam int         BIT_PAGE_ERASE   = 1;
    localparam int         BIT_PAGE_WRITE   = 2;
    localparam int         BIT_LOCK_SET     = 3;
    localparam int         BIT_APP_READ_EN  = 4;
    localparam int         BIT_APP_BUSY     = 6;
    localparam logic [7:0] CTRL_RESET       = 8'h00;
    localparam logic [4:0] PAT_APP_READ     = 5'h11;
    localparam logic [4:0] PAT_LOCK_SET     = 5'h09;
    localparam logic [4:0] PAT_PAGE_WRITE   = 5'h05;
    localparam logic [4:0] PAT_PAGE_ERASE   = 5'h03;
    localparam logic [4:0] PAT_FILL         = 5'h01;
    localparam logic [2:0] STORE_WINDOW     = 3'h4;
    localparam logic [2:0] LOAD_WINDOW      = 3'h5;
    localparam int         OP_TIME_NS       = 4000;
    localparam int         CLK_PERIOD_NS    = 25;
    localparam int         OP_CYCLES        = OP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] LOCK_RESET       = 8'hff;
    localparam logic [7:0] FUSE_LOW_RESET   = 8'hff;
    localparam logic [7:0] FUSE_HIGH_RESET  = 8'hff;
    localparam logic [1:0] ADDR_FUSE_LOW    = 2'h0;
    localparam logic [1:0] ADDR_LOCK        = 2'h1;
    localparam logic [1:0] ADDR_FUSE_HIGH   = 2'h3;
    localparam int         LOCK_FIELD_LSB   = 2;
    localparam int         LOCK_FIELD_W     = 4;
    typedef enum logic [1:0] {
        FSP_OP_NONE, FSP_OP_FILL, FSP_OP_ERASE, FSP_OP_WRITE
    } fsp_op_t;
endpackage : fsp_pkg

// ===== hdl/fsp_if.sv
interface fsp_if;
    logic [7:0]  io_addr;
    logic [7:0]  io_wdata;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_rdata;
    logic [15:0] pointer;
    logic [7:0]  data_low_reg;
    logic [7:0]  data_high_reg;
    logic        store_strobe;
    logic        load_strobe;
    logic [7:0]  load_data;
    logic        load_valid;
    logic        halt;
    logic        store_done;
    modport dev (input io_addr, io_wdata, io_wr, io_rd, pointer,
                 data_low_reg, data_high_reg, store_strobe, load_strobe,
                 output io_rdata, load_data, load_valid, halt, store_done);
    modport cpu (output io_addr, io_wdata, io_wr, io_rd, pointer,
                 data_low_reg, data_high_reg, store_strobe, load_strobe,
                 input io_rdata, load_data, load_valid, halt, store_done);
endinterface : fsp_if

// ===== hdl/fsp_cpu.sv
module fsp_cpu
    import fsp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    fsp_if.cpu               bus,
    input  wire logic        cmd_valid,
    input  wire logic [4:0]  cmd_ctrl,
    input  wire logic        cmd_load,
    input  wire logic [15:0] cmd_pointer,
    input  wire logic [15:0] cmd_data,
    input  wire logic        eeprom_write_busy,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data
);
    typedef enum logic [1:0] {
        FSP_C_IDLE, FSP_C_ARM, FSP_C_ISSUE, FSP_C_WAIT
    } fsp_cpu_st_t;

    typedef struct packed {
        fsp_cpu_st_t st;
        logic        load;
        logic [4:0]  ctrl;
        logic [15:0] ptr;
        logic [15:0] data;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic        ss;
        logic        ls;
        logic        rv;
        logic [7:0]  rdat;
    } fsp_cpu_state_t;

    fsp_cpu_state_t s_reg;
    fsp_cpu_state_t s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.wr = 1'b0;
        s_next.rd = 1'b0;
        s_next.ss = 1'b0;
        s_next.ls = 1'b0;
        s_next.rv = 1'b0;
        unique case (s_reg.st)
            FSP_C_IDLE: if (cmd_valid) begin
                s_next.load = cmd_load;
                s_next.ctrl = cmd_ctrl;
                s_next.ptr  = cmd_pointer;
                s_next.data = cmd_data;
                s_next.st   = FSP_C_ARM;
            end
            FSP_C_ARM: if (!eeprom_write_busy) begin
                s_next.wr    = 1'b1;
                s_next.wdata = {3'b000, s_reg.ctrl};
                s_next.st    = FSP_C_ISSUE;
            end
            FSP_C_ISSUE: begin
                // Strobe follows the control write at once.
                s_next.ss = !s_reg.load;
                s_next.ls = s_reg.load;
                s_next.st = FSP_C_WAIT;
            end
            FSP_C_WAIT: if (bus.load_valid || bus.store_done) begin
                s_next.rv   = 1'b1;
                s_next.rdat = bus.load_data;
                s_next.st   = FSP_C_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            s_reg <= '{st: FSP_C_IDLE, default: '0};
        else if (ce && !(bus.halt && s_reg.st == FSP_C_IDLE))
            s_reg <= s_next;
    end

    // Same page for erase and write and zero word bits are the caller's
    // concern; the pointer is passed as given.
    assign bus.io_addr       = CTRL_OFFSET;
    assign bus.io_wdata      = s_reg.wdata;
    assign bus.io_wr         = s_reg.wr;
    assign bus.io_rd         = s_reg.rd;
    assign bus.pointer       = s_reg.ptr;
    assign bus.data_low_reg  = s_reg.data[7:0];
    assign bus.data_high_reg = s_reg.data[15:8];
    assign bus.store_strobe  = s_reg.ss;
    assign bus.load_strobe   = s_reg.ls;
    assign cmd_ready         = s_reg.st == FSP_C_IDLE && !bus.halt;
    assign rsp_valid         = s_reg.rv;
    assign rsp_data          = s_reg.rdat;
endmodule : fsp_cpu

// ===== bench/fsp_chk.sv
module fsp_chk
    import fsp_pkg::*;
#(
    parameter int OP_CNT = 4
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] io_addr,
    input wire logic       io_wr,
    input wire logic       store_strobe,
    input wire logic       load_strobe,
    input wire logic       load_valid,
    input wire logic       halt,
    input wire logic       store_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] halt_len_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Counts the cycles of the running halt so its length can be judged.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halt_len_reg <= 16'h0000;
        end else begin
            halt_len_reg <= halt ? halt_len_reg + 16'h0001 : 16'h0000;
        end
    end

    halt_cause_a:
        assert property ($rose(halt) |-> $past(store_strobe))
        else $error("halt without store");
    halt_length_a:
        assert property ($fell(halt) |->
            halt_len_reg >= OP_CNT && halt_len_reg <= OP_CNT + 1)
        else $error("halt length wrong");
    op_done_a:
        assert property ($fell(halt) |-> ##[0:1] store_done)
        else $error("no done at op end");
    halt_quiet_a:
        assert property (halt |-> !store_strobe && !load_strobe)
        else $error("strobe while halted");
    load_answer_a:
        assert property (load_strobe |=> load_valid)
        else $error("load not answered");
    load_cause_a:
        assert property (load_valid |-> $past(load_strobe))
        else $error("load answer without load");
    store_answer_a:
        assert property (store_strobe |=> store_done || halt)
        else $error("store not answered");
    strobe_armed_a:
        assert property (store_strobe || load_strobe |->
            $past(io_wr) && $past(io_addr) == CTRL_OFFSET)
        else $error("strobe without control write");
endmodule : fsp_chk

// ===== bench/flash_self_program_control_tb.sv
module flash_self_program_control_tb
    import fsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OPN = 4;
    logic        clk, rst, rst2, ee2, ce2, cv, cl, ready, rv, fov, fov2, are;
    logic [4:0]  cc;
    logic [7:0]  rd, fpage;
    logic [15:0] cp, cd, fword;
    fsp_op_t     fop;
    int          err_total, checks_done;
    fsp_if b1();
    fsp_if b2();

    fsp_cpu fsp_cpu_inst (.clk(clk), .rst(rst), .ce(1'b1), .bus(b1.cpu),
        .cmd_valid(cv), .cmd_ctrl(cc), .cmd_load(cl), .cmd_pointer(cp),
        .cmd_data(cd), .eeprom_write_busy(ee2), .cmd_ready(ready),
        .rsp_valid(rv), .rsp_data(rd));
    fsp_device #(.OP_CNT(OPN)) fsp_device_inst (.clk(clk), .rst(rst),
        .ce(1'b1), .bus(b1.dev), .eeprom_write_busy(ee2),
        .flash_op_valid(fov), .flash_op(fop), .flash_page(fpage),
        .flash_word(fword), .app_section_read_enable(are));
    // Second device, driven directly so that misbehaving software can be made.
    fsp_device #(.OP_CNT(OPN)) fsp_device_inst_b (.clk(clk), .rst(rst2),
        .ce(ce2), .bus(b2.dev), .eeprom_write_busy(ee2),
        .flash_op_valid(fov2), .flash_op(), .flash_page(), .flash_word(),
        .app_section_read_enable());
    fsp_chk #(.OP_CNT(OPN)) fsp_chk_inst (.clk(clk), .rst(rst),
        .io_addr(b1.io_addr), .io_wr(b1.io_wr),
        .store_strobe(b1.store_strobe), .load_strobe(b1.load_strobe),
        .load_valid(b1.load_valid), .halt(b1.halt),
        .store_done(b1.store_done));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    function automatic logic pick(input int s);
        case (s)
            0: return fov;
            1: return rv;
            2: return fov2;
            3: return b2.halt;
            4: return b2.load_valid;
            5: return b1.store_done;
            default: return !b2.halt;
        endcase
    endfunction : pick

    task automatic await(input int s, input int lim, input logic want);
        int n;
        n = 0;
        @(negedge clk);
        while (pick(s) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        check({15'h0, pick(s)}, {15'h0, want});
        if (want && n == lim) summarize();
    endtask : await

    task automatic cmd(input logic [4:0] c, input logic ld,
                       input logic [15:0] p, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cv, cc, cl, cp, cd} <= {1'b1, c, ld, p, d};
        @(negedge clk);
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check({15'h0, ready}, 16'h0001);
        if (ready !== 1'b1) summarize();
        @(posedge clk);
        cv <= 1'b0;
    endtask : cmd

    task automatic bus2(input logic wr, input logic [7:0] a, d);
        @(posedge clk);
        {b2.io_addr, b2.io_wdata, b2.io_wr, b2.io_rd} <= {a, d, wr, !wr};
        @(posedge clk);
        {b2.io_wr, b2.io_rd} <= 2'b00;
    endtask : bus2

    task automatic rd2(input logic [7:0] a, input logic [7:0] exp);
        bus2(1'b0, a, 8'h00);
        @(negedge clk);
        check({8'h0, b2.io_rdata}, {8'h0, exp});
    endtask : rd2

    task automatic probe(input logic [7:0] ctl, input logic ld,
                         input int gap, input int s, input logic want);
        bus2(1'b1, CTRL_OFFSET, ctl);
        repeat (gap - 1) @(posedge clk);
        {b2.store_strobe, b2.load_strobe} <= {!ld, ld};
        @(posedge clk);
        {b2.store_strobe, b2.load_strobe} <= 2'b00;
        await(s, 8, want);
    endtask : probe

    task automatic fill_case();
        ee2 <= 1'b1;
        cmd(PAT_FILL, 1'b0, 16'h007e, 16'ha55a);
        await(0, 10, 1'b0);
        @(posedge clk);
        ee2 <= 1'b0;
        await(0, 10, 1'b1);
        check({14'h0, fop}, {14'h0, FSP_OP_FILL});
        check(fword, 16'ha55a);
    endtask : fill_case

    task automatic page_op(input logic [4:0] c, input logic [15:0] p,
                           input fsp_op_t op, input logic [7:0] pg);
        cmd(c, 1'b0, p, 16'h5aa5);
        await(0, 10, 1'b1);
        check({14'h0, fop}, {14'h0, op});
        check({8'h0, fpage}, {8'h0, pg});
        check(fword, {8'h00, pg});
        await(5, 20, 1'b1);
    endtask : page_op

    task automatic lock_read(input logic [15:0] p, input logic [7:0] exp);
        cmd(PAT_LOCK_SET, 1'b1, p, 16'h0000);
        await(1, 10, 1'b1);
        check({8'h0, rd}, {8'h0, exp});
    endtask : lock_read

    task automatic lock_case();
        lock_read(16'h0000, FUSE_LOW_RESET);
        lock_read(16'h0003, FUSE_HIGH_RESET);
        cmd(PAT_LOCK_SET, 1'b0, 16'hbeee, 16'h00c3);
        await(5, 10, 1'b1);
        lock_read(16'h0001, LOCK_RESET & 8'hc3);
        cmd(PAT_APP_READ, 1'b0, 16'h0000, 16'h0000);
        await(5, 10, 1'b1);
        @(negedge clk);
        check({15'h0, are}, 16'h0001);
    endtask : lock_case

    task automatic reg_case();
        bus2(1'b1, CTRL_OFFSET, 8'hff);
        rd2(CTRL_OFFSET, 8'h00);
        bus2(1'b1, CTRL_OFFSET, 8'he1);
        rd2(CTRL_OFFSET, 8'h01);
        repeat (4) @(posedge clk);
        rd2(CTRL_OFFSET, CTRL_RESET);
        rd2(8'h38, 8'h00);
    endtask : reg_case

    task automatic window_case();
        logic [7:0] pats [4] = '{8'h07, 8'h1f, 8'h0b, 8'h13};
        probe(8'h01, 1'b0, 4, 2, 1'b1);
        probe(8'h01, 1'b0, 5, 2, 1'b0);
        probe(8'h03, 1'b0, 5, 3, 1'b0);
        probe(8'h05, 1'b0, 5, 3, 1'b0);
        probe(8'h09, 1'b1, 5, 4, 1'b1);
        check({8'h0, b2.load_data}, {8'h0, FUSE_LOW_RESET});
        probe(8'h09, 1'b1, 6, 4, 1'b0);
        foreach (pats[i]) probe(pats[i], 1'b0, 1, 2, 1'b0);
        @(posedge clk);
        ee2 <= 1'b1;
        probe(8'h01, 1'b0, 1, 2, 1'b0);
        probe(8'h09, 1'b1, 1, 4, 1'b0);
        @(posedge clk);
        ee2 <= 1'b0;
    endtask : window_case

    task automatic freeze_case();
        bus2(1'b1, CTRL_OFFSET, 8'h01);
        ce2 <= 1'b0;
        repeat (6) @(posedge clk);
        ce2 <= 1'b1;
        {b2.store_strobe, b2.load_strobe} <= 2'b10;
        @(posedge clk);
        {b2.store_strobe, b2.load_strobe} <= 2'b00;
        await(2, 8, 1'b1);
    endtask : freeze_case

    task automatic reset_case();
        probe(8'h05, 1'b0, 1, 3, 1'b1);
        rd2(CTRL_OFFSET, 8'h05);
        await(6, 12, 1'b1);
        check({15'h0, b2.store_done}, 16'h0001);
        probe(8'h03, 1'b0, 1, 3, 1'b1);
        @(posedge clk);
        rst2 <= 1'b1;
        @(negedge clk);
        check({15'h0, b2.halt}, 16'h0001);
        @(posedge clk);
        rst2 <= 1'b0;
        await(6, 12, 1'b1);
        check({15'h0, b2.store_done}, 16'h0001);
    endtask : reset_case

    initial begin
        rst = 1'b1;
        rst2 = 1'b1;
        {ee2, cv, cl, cc, cp, cd} = '0;
        {b2.io_addr, b2.io_wdata, b2.io_wr, b2.io_rd, b2.store_strobe,
         b2.load_strobe, b2.data_low_reg, b2.data_high_reg} = '0;
        b2.pointer = 16'h0080;
        ce2 = 1'b1;
        err_total = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rst2 <= 1'b0;
        fill_case();
        page_op(PAT_PAGE_ERASE, 16'hc080, FSP_OP_ERASE, 8'h81);
        page_op(PAT_PAGE_WRITE, 16'h0100, FSP_OP_WRITE, 8'h02);
        lock_case();
        reg_case();
        window_case();
        freeze_case();
        reset_case();
        summarize();
    end
endmodule : flash_self_program_control_tb
